// *** logic/aoar_defs.vh ***
// Register offsets, field layout and reset values of the offset trim bank
`ifndef AOAR_DEFS_VH
`define AOAR_DEFS_VH
`define AOAR_OFS_CORE1_INA 8'h8e
`define AOAR_OFS_CORE1_INB 8'h90
`define AOAR_OFS_CORE2_INA 8'h92
`define AOAR_OFS_CAL_CTRL 8'ha0
`define AOAR_OFS_CAL_STAT 8'ha4
`define AOAR_TRIM_MSB 11
`define AOAR_RSV_MSB 15
`define AOAR_RSV_LSB 12
`define AOAR_RSV_RESET 4'h0
`define AOAR_CTRL_BG 0
`define AOAR_CTRL_BGOS 1
`define AOAR_CTRL_FGOS 2
`define AOAR_STAT_FGDONE 0
`define AOAR_STAT_HALTED 1
`define AOAR_STAT_FGRUN 2
`define AOAR_STAT_WRBLK 3
`define AOAR_STAT_RDBAD 4
`define AOAR_STAT_VIOL 5
`define AOAR_RESP_OKAY 2'b00
`define AOAR_RESP_SLVERR 2'b10
`endif

// *** logic/aoar_sync.v ***
// Two-flop synchroniser for calibration engine status levels
module aoar_sync #(
  parameter WIDTH = 3
) (
  input wire i_clock,
  input wire i_rstn,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule // aoar_sync

// *** logic/aoar_trim_reg.v ***
// One 16-bit offset trim register with factory load and byte-lane writes
`include "aoar_defs.vh"
module aoar_trim_reg (
  input wire i_clock,
  input wire i_rstn,
  input wire i_load,
  input wire [11:0] i_factory,
  input wire i_wr,
  input wire [1:0] i_lanes,
  input wire [15:0] i_wdata,
  output wire [15:0] o_value
);
  reg [15:0] value_q;
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      value_q <= 16'h0000;
    end else if (i_load) begin
      // Factory trim loaded right after reset release; reserved bits to zero
      value_q <= {`AOAR_RSV_RESET, i_factory}; // [RL3] [RL1]
    end else if (i_wr) begin
      if (i_lanes[0]) begin
        value_q[7:0] <= i_wdata[7:0]; // [RL10]
      end
      if (i_lanes[1]) begin
        value_q[15:8] <= i_wdata[15:8]; // [RL10]
      end
    end
  end
  assign o_value = value_q;
endmodule // aoar_trim_reg

// *** logic/aoar_regs.v ***
// Offset trim register bank of the converter cores, AXI4-Lite slave
// How it works
// RL1: 12-bit trim for second core on input A; top nibble reserved RW, resets 0.
// RL2: Second core input B trim lives at bytes 0x090-0x091.
// RL3: After reset each trim shows its factory value; software may overwrite.
// RL4: Host must not write trims during a foreground calibration run.
// RL5: Host must not write trims while both background enables are set.
// RL6: Foreground-only offset cal: read trims only after foreground complete reads 1.
// RL7: Background offset cal running: read trims only while halted flag reads 1.
// RL8: Third core input A trim at bytes 0x092-0x093, same layout.
// RL9: Second core input A trim lives at bytes 0x08E-0x08F.
// RL10: Low byte address holds bits 7:0, high byte address bits 15:8.
//
// Register access over AXI4-Lite is this design's own decision.
`include "aoar_defs.vh"
module aoar_regs #(
  parameter [11:0] FACTORY_CORE1_INA = 12'h800,
  parameter [11:0] FACTORY_CORE1_INB = 12'h800,
  parameter [11:0] FACTORY_CORE2_INA = 12'h800
) (
  input wire i_clock,
  input wire i_rstn,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output wire [1:0] o_bresp,
  output wire o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  output wire o_rvalid,
  input wire i_rready,
  input wire i_fg_cal_running,
  input wire i_foreground_cal_complete,
  input wire i_background_cal_halted,
  output wire [11:0] o_trim_core1_input_a,
  output wire [11:0] o_trim_core1_input_b,
  output wire [11:0] o_trim_core2_input_a,
  output wire o_background_cal_enable,
  output wire o_background_offset_cal_enable,
  output wire o_foreground_offset_cal_enable
);
  // Synchronised calibration engine status
  wire [2:0] cal_sync;
  aoar_sync #(.WIDTH(3)) u_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_async({i_background_cal_halted, i_foreground_cal_complete, i_fg_cal_running}),
    .o_sync(cal_sync)
  );
  wire fg_run = cal_sync[0];
  wire foreground_cal_complete = cal_sync[1];
  wire bg_halted = cal_sync[2];

  // Load pulse one cycle after reset release, so the factory value is clocked in
  reg load_done_q;
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      load_done_q <= 1'b0;
    end else begin
      load_done_q <= 1'b1;
    end
  end
  wire load = !load_done_q;

  // Trim index; trims sit on two-byte boundaries, so they share words by halves
  function [1:0] trim_sel;
    input [7:0] addr;
    begin
      case (addr & 8'hfe)
        `AOAR_OFS_CORE1_INA: trim_sel = 2'd1;
        `AOAR_OFS_CORE1_INB: trim_sel = 2'd2;
        `AOAR_OFS_CORE2_INA: trim_sel = 2'd3;
        default: trim_sel = 2'd0;
      endcase
    end
  endfunction

  // Control and status each own one aligned word; low address bits are ignored
  function is_ctrl;
    input [7:0] addr;
    begin
      is_ctrl = ((addr & 8'hfc) == `AOAR_OFS_CAL_CTRL);
    end
  endfunction

  function is_stat;
    input [7:0] addr;
    begin
      is_stat = ((addr & 8'hfc) == `AOAR_OFS_CAL_STAT);
    end
  endfunction

  // Write channel
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg [7:0] ctrl_q;
  reg wr_blk_q;
  reg rd_bad_q;

  assign o_awready = !aw_have_q && !bvalid_q;
  assign o_wready = !w_have_q && !bvalid_q;
  wire aw_take = i_awvalid && o_awready;
  wire w_take = i_wvalid && o_wready;
  wire b_done = bvalid_q && i_bready;
  wire aw_ctrl = is_ctrl(awaddr_q);
  wire aw_stat = is_stat(awaddr_q);
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire [1:0] wsel = trim_sel(awaddr_q);
  // Each 16-bit trim takes its byte lanes at the halfword position in the word
  wire [1:0] wlanes = awaddr_q[1] ? wstrb_q[3:2] : wstrb_q[1:0];
  wire [15:0] whalf = awaddr_q[1] ? wdata_q[31:16] : wdata_q[15:0];
  // Trim writes are refused while fg_run (foreground running, two clocks late through the synchroniser) is set or both background enables are set
  wire wr_forbid = fg_run || (ctrl_q[`AOAR_CTRL_BG] && ctrl_q[`AOAR_CTRL_BGOS]); // [RL4] [RL5]
  wire trim_wr = wr_go && (wsel != 2'd0) && !wr_forbid;
  wire ctrl_wr = wr_go && aw_ctrl && wstrb_q[0];
  wire wr_refused = wr_go && (wsel != 2'd0) && wr_forbid; // [RL4] [RL5]

  // Only the three enable bits are kept; the rest of the control byte reads zero
  reg [7:0] ctrl_d;
  always @* begin
    ctrl_d = 8'h00;
    ctrl_d[`AOAR_CTRL_BG] = wdata_q[`AOAR_CTRL_BG];
    ctrl_d[`AOAR_CTRL_BGOS] = wdata_q[`AOAR_CTRL_BGOS];
    ctrl_d[`AOAR_CTRL_FGOS] = wdata_q[`AOAR_CTRL_FGOS];
  end

  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      awaddr_q <= 8'h00;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `AOAR_RESP_OKAY;
      ctrl_q <= 8'h00;
    end else begin
      if (aw_take) begin
        awaddr_q <= i_awaddr;
        aw_have_q <= 1'b1;
      end
      if (w_take) begin
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        if (wsel != 2'd0) begin
          bresp_q <= wr_forbid ? `AOAR_RESP_SLVERR : `AOAR_RESP_OKAY;
        end else if (aw_ctrl || aw_stat) begin
          // Status is read-only; a write there is accepted and ignored
          bresp_q <= `AOAR_RESP_OKAY;
        end else begin
          bresp_q <= `AOAR_RESP_SLVERR;
        end
      end else if (b_done) begin
        bvalid_q <= 1'b0;
      end
      if (ctrl_wr) begin
        ctrl_q <= ctrl_d;
      end
    end
  end

  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;

  // Trim registers
  wire [15:0] trim0;
  wire [15:0] trim1;
  wire [15:0] trim2;
  aoar_trim_reg u_core1_ina (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_load(load),
    .i_factory(FACTORY_CORE1_INA),
    .i_wr(trim_wr && (wsel == 2'd1)), // [RL9] [RL1]
    .i_lanes(wlanes),
    .i_wdata(whalf),
    .o_value(trim0)
  );
  aoar_trim_reg u_core1_inb (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_load(load),
    .i_factory(FACTORY_CORE1_INB),
    .i_wr(trim_wr && (wsel == 2'd2)), // [RL2]
    .i_lanes(wlanes),
    .i_wdata(whalf),
    .o_value(trim1)
  );
  aoar_trim_reg u_core2_ina (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_load(load),
    .i_factory(FACTORY_CORE2_INA),
    .i_wr(trim_wr && (wsel == 2'd3)), // [RL8]
    .i_lanes(wlanes),
    .i_wdata(whalf),
    .o_value(trim2)
  );
  // Trims drive the sampling cores directly
  assign o_trim_core1_input_a = trim0[`AOAR_TRIM_MSB:0]; // [RL1]
  assign o_trim_core1_input_b = trim1[`AOAR_TRIM_MSB:0]; // [RL2]
  assign o_trim_core2_input_a = trim2[`AOAR_TRIM_MSB:0]; // [RL8]
  assign o_background_cal_enable = ctrl_q[`AOAR_CTRL_BG];
  assign o_background_offset_cal_enable = ctrl_q[`AOAR_CTRL_BGOS];
  assign o_foreground_offset_cal_enable = ctrl_q[`AOAR_CTRL_FGOS];

  // Read channel; reads in a forbidden window still answer but are flagged
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  assign o_arready = !rvalid_q;
  wire rd_unsafe =
    (ctrl_q[`AOAR_CTRL_FGOS] && !ctrl_q[`AOAR_CTRL_BGOS] && !foreground_cal_complete) || // [RL6]
    (ctrl_q[`AOAR_CTRL_BG] && ctrl_q[`AOAR_CTRL_BGOS] && !bg_halted); // [RL7]
  wire [1:0] rsel = trim_sel(i_araddr);
  wire ar_take = i_arvalid && o_arready;
  wire r_done = rvalid_q && i_rready;
  wire ar_ctrl = is_ctrl(i_araddr);
  wire ar_stat = is_stat(i_araddr);
  reg [15:0] rhalf;
  always @* begin
    case (rsel)
      2'd1: rhalf = trim0;
      2'd2: rhalf = trim1;
      2'd3: rhalf = trim2;
      default: rhalf = 16'h0000;
    endcase
  end

  // Control read-back mirrors the stored enables bit for bit
  reg [31:0] ctrl_word;
  always @* begin
    ctrl_word = 32'h00000000;
    ctrl_word[`AOAR_CTRL_BG] = ctrl_q[`AOAR_CTRL_BG];
    ctrl_word[`AOAR_CTRL_BGOS] = ctrl_q[`AOAR_CTRL_BGOS];
    ctrl_word[`AOAR_CTRL_FGOS] = ctrl_q[`AOAR_CTRL_FGOS];
  end

  // Status word built from the field positions so software sees one layout
  reg [31:0] stat_word;
  always @* begin
    stat_word = 32'h00000000;
    stat_word[`AOAR_STAT_FGDONE] = foreground_cal_complete;
    stat_word[`AOAR_STAT_HALTED] = bg_halted;
    stat_word[`AOAR_STAT_FGRUN] = fg_run;
    stat_word[`AOAR_STAT_WRBLK] = wr_blk_q;
    stat_word[`AOAR_STAT_RDBAD] = rd_bad_q;
    stat_word[`AOAR_STAT_VIOL] = wr_forbid;
  end

  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `AOAR_RESP_OKAY;
      wr_blk_q <= 1'b0;
      rd_bad_q <= 1'b0;
    end else begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rresp_q <= `AOAR_RESP_OKAY;
        if (rsel != 2'd0) begin
          // Halfword placed in its byte lanes: low address in bits 7:0 of the half
          rdata_q <= i_araddr[1] ? {rhalf, 16'h0000} : {16'h0000, rhalf}; // [RL10]
          if (rd_unsafe) begin
            rd_bad_q <= 1'b1;
          end
        end else if (ar_ctrl) begin
          rdata_q <= ctrl_word;
        end else if (ar_stat) begin
          rdata_q <= stat_word;
          // Sticky flags clear on status read
          wr_blk_q <= 1'b0;
          rd_bad_q <= 1'b0;
        end else begin
          rdata_q <= 32'h00000000;
          rresp_q <= `AOAR_RESP_SLVERR;
        end
      end else if (r_done) begin
        rvalid_q <= 1'b0;
      end
      // A refused write sets the flag; the set wins over a clearing read
      if (wr_refused) begin
        wr_blk_q <= 1'b1;
      end
    end
  end
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
endmodule // aoar_regs

// *** test/aoar_regs_assertions.sv ***
// Port-level checker for the offset trim register bank
`include "aoar_defs.vh"
module aoar_regs_chk (
  input wire i_clock,
  input wire i_rstn,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  input wire o_awready,
  input wire i_wvalid,
  input wire o_wready,
  input wire [1:0] o_bresp,
  input wire o_bvalid,
  input wire i_bready,
  input wire i_arvalid,
  input wire o_arready,
  input wire [31:0] o_rdata,
  input wire o_rvalid,
  input wire i_rready,
  input wire [11:0] o_trim_core1_input_a,
  input wire [11:0] o_trim_core1_input_b,
  input wire [11:0] o_trim_core2_input_a,
  input wire o_background_cal_enable,
  input wire o_background_offset_cal_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence ar_take;
    i_arvalid && o_arready;
  endsequence
  ar_gate_a: assert property (o_arready == !o_rvalid) else $error("arready not inverse of rvalid");
  read_answer_a: assert property (ar_take |=> o_rvalid) else $error("read not answered");
  write_answer_a: assert property (wr_take |-> ##2 o_bvalid) else $error("write not answered");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read answer dropped");
  bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped");
  one_write_a: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("second write");
  trim_change_a: assert property ($past(i_rstn, 2) &&
    !$stable({o_trim_core1_input_a, o_trim_core1_input_b, o_trim_core2_input_a})
    |-> $rose(o_bvalid)) else $error("trim moved");
  bg_block_a: assert property (o_background_cal_enable && o_background_offset_cal_enable
    && i_awaddr < 8'ha0 ##0 wr_take |-> ##2 o_bresp == `AOAR_RESP_SLVERR) else $error("write taken");
endmodule // aoar_regs_chk
bind aoar_regs aoar_regs_chk u_chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_awaddr(i_awaddr),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_trim_core1_input_a(o_trim_core1_input_a), .o_trim_core1_input_b(o_trim_core1_input_b),
  .o_trim_core2_input_a(o_trim_core2_input_a), .o_background_cal_enable(o_background_cal_enable),
  .o_background_offset_cal_enable(o_background_offset_cal_enable));

// *** test/aoar_regs_tb.sv ***
// Testbench of the offset trim register bank
`include "aoar_defs.vh"
module aoar_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg i_clock, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, fg_run, foreground_cal_complete, halt;
  reg [7:0] i_awaddr, i_araddr;
  reg [31:0] i_wdata;
  reg [3:0] i_wstrb;
  wire awr, wr_rdy, bv, arr, rv, bg, bgos, fgos;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [11:0] ta, tb, tc;
  reg [31:0] rd_q;
  reg [1:0] resp_q;
  integer error_cnt = 0;
  integer num_checks = 0;
  aoar_regs uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(awr), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(wr_rdy),
    .o_bresp(br), .o_bvalid(bv), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(i_rready),
    .i_fg_cal_running(fg_run), .i_foreground_cal_complete(foreground_cal_complete),
    .i_background_cal_halted(halt), .o_trim_core1_input_a(ta), .o_trim_core1_input_b(tb),
    .o_trim_core2_input_a(tc), .o_background_cal_enable(bg),
    .o_background_offset_cal_enable(bgos), .o_foreground_offset_cal_enable(fgos));
  initial begin
    i_clock = 1'h0;
    forever #25 i_clock = ~i_clock;
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Handshakes are judged at the falling edge, where all signals have settled
  task xfer(input wr, input [1:0] er);
    integer n;
    reg ta_, tw, tk, v;
    begin
      tk = 1'h0;
      for (n = 0; n < 40 && !tk; n = n + 1) begin
        @(negedge i_clock);
        ta_ = wr ? i_awvalid && awr : i_arvalid && arr;
        tw = i_wvalid && wr_rdy;
        v = wr ? bv : rv;
        tk = wr ? i_bready && bv : i_rready && rv;
        resp_q = wr ? br : rr;
        rd_q = rdat;
        @(posedge i_clock);
        if (ta_ && wr) i_awvalid <= 1'h0;
        if (ta_ && !wr) i_arvalid <= 1'h0;
        if (tw) i_wvalid <= 1'h0;
        if (wr) i_bready <= v && !tk;
        else i_rready <= v && !tk;
      end
      if (!tk) begin
        $display("[ERR] %0t got %h exp %h", $time, 1'h0, 1'h1);
        error_cnt = error_cnt + 1;
        print_verdict;
      end else begin
        chk(resp_q, er);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    begin
      i_awaddr <= a;
      i_wdata <= d;
      i_wstrb <= s;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      xfer(1'h1, er);
    end
  endtask
  task rd(input [7:0] a, input [1:0] er);
    begin
      i_araddr <= a;
      i_arvalid <= 1'h1;
      xfer(1'h0, er);
    end
  endtask
  task wt(input [7:0] a, input [15:0] d, input [1:0] s, input [1:0] er);
    wr(a, a[1] ? {d, 16'h0} : {16'h0, d}, a[1] ? {s, 2'h0} : {2'h0, s}, er);
  endtask
  task rt(input [7:0] a, input [15:0] e);
    begin
      rd(a, `AOAR_RESP_OKAY);
      chk(a[1] ? rd_q[31:16] : rd_q[15:0], e);
    end
  endtask
  task stat(input [31:0] m, input [31:0] e);
    begin
      rd(8'ha4, `AOAR_RESP_OKAY);
      chk(rd_q & m, e);
    end
  endtask
  initial begin
    {i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, fg_run, foreground_cal_complete, halt} = 9'h0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = 52'h0;
    repeat (12) @(posedge i_clock);
    i_rstn <= 1'h1;
    repeat (2) @(posedge i_clock);
    rt(8'h8e, 16'h0800);
    rt(8'h90, 16'h0800);
    rt(8'h92, 16'h0800);
    $display("reset values test done");
    wt(8'h8e, 16'hf123, 2'h3, `AOAR_RESP_OKAY);
    wt(8'h90, 16'h0456, 2'h3, `AOAR_RESP_OKAY);
    wt(8'h92, 16'h0789, 2'h3, `AOAR_RESP_OKAY);
    rt(8'h8e, 16'hf123);
    chk(ta, 12'h123);
    chk(tb, 12'h456);
    chk(tc, 12'h789);
    wt(8'h90, 16'h00aa, 2'h1, `AOAR_RESP_OKAY);
    rt(8'h90, 16'h04aa);
    wt(8'h92, 16'h5500, 2'h2, `AOAR_RESP_OKAY);
    rt(8'h92, 16'h5589);
    $display("layout test done");
    fg_run <= 1'h1;
    repeat (4) @(posedge i_clock);
    wt(8'h90, 16'h0111, 2'h3, `AOAR_RESP_SLVERR);
    rt(8'h90, 16'h04aa);
    stat(32'h3f, 32'h2c);
    fg_run <= 1'h0;
    wr(8'ha0, 32'h3, 4'h1, `AOAR_RESP_OKAY);
    chk({fgos, bgos, bg}, 3'h3);
    repeat (4) @(posedge i_clock);
    wt(8'h8e, 16'h0222, 2'h3, `AOAR_RESP_SLVERR);
    rt(8'h8e, 16'hf123);
    stat(32'h3f, 32'h38);
    halt <= 1'h1;
    repeat (4) @(posedge i_clock);
    rt(8'h92, 16'h5589);
    stat(32'h3f, 32'h22);
    wr(8'ha0, 32'h4, 4'h1, `AOAR_RESP_OKAY);
    chk({fgos, bgos, bg}, 3'h4);
    rt(8'h90, 16'h04aa);
    stat(32'h3f, 32'h12);
    foreground_cal_complete <= 1'h1;
    repeat (4) @(posedge i_clock);
    rt(8'h90, 16'h04aa);
    stat(32'h3f, 32'h03);
    rd(8'h00, `AOAR_RESP_SLVERR);
    chk(rd_q, 32'h0);
    $display("access window test done");
    print_verdict;
  end
endmodule // aoar_regs_tb
